/* File: design/rivp_pkg.sv */
// Purpose: constants for the reset and interrupt vector placement block
// Assumes: word addressed program memory, two words per vector slot
// Notes: shared by the design and its bench
package rivp_pkg;

  // -------------------------------------------------------------
  // addresses and slots
  // -------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int NUM_SRC = 20;
  localparam logic [13:0] RESET_ADDR = 14'h0000;
  localparam logic [13:0] TABLE_OFFSET = 14'h0002;
  localparam int SLOT_SHIFT = 1;

  // -------------------------------------------------------------
  // fuse coding and timing
  // -------------------------------------------------------------
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam int UNLOCK_CYCLES = 4;
  localparam logic [2:0] UNLOCK_LOAD = 3'h4;
  localparam logic [1:0] SETTLE_LOAD = 2'h3;

  typedef enum logic [1:0] {
    RIVP_SETTLE,
    RIVP_BOOT,
    RIVP_RUN
  } rivp_phase_type;

endpackage

/* File: design/rivp_vector_place.sv */
// Purpose: reset target and interrupt vector address generation
// Assumes: requests and control strobes come from logic on clk
// Notes: the fuse is a pin and passes a three stage synchroniser
`timescale 1ns/100ps
module rivp_vector_place #(
  parameter int ADDR_W = rivp_pkg::ADDR_W,
  parameter int NUM_SRC = rivp_pkg::NUM_SRC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic boot_reset_select_fuse,
  input wire logic [ADDR_W-1:0] boot_reset_addr,
  input wire logic [NUM_SRC-1:0] irq_request,
  input wire logic global_irq_enable,
  input wire logic irq_take,
  input wire logic instr_done,
  input wire logic ctl_write,
  input wire logic ctl_unlock_wr,
  input wire logic ctl_select_wr,
  output logic reset_load_valid,
  output logic [ADDR_W-1:0] pc_load_addr,
  output logic irq_valid,
  output logic [ADDR_W-1:0] irq_vector_addr,
  output logic [4:0] irq_number,
  output logic vector_table_select,
  output logic vector_change_unlock,
  output logic irq_blocked
);

  // -------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------
  // refused while elaborating, so a bad size never reaches a run
  if (NUM_SRC < 1 || NUM_SRC > 32 || ((NUM_SRC + 1) << 1) >= (1 << ADDR_W)) begin
    $error("rivp_vector_place: sources do not fit address width");
  end

  typedef struct packed {
    logic [2:0] fuse_sync;
    logic fuse_prog;
    rivp_pkg::rivp_phase_type phase;
    logic [1:0] settle;
    logic reset_load_valid;
    logic [ADDR_W-1:0] pc_load_addr;
    logic irq_valid;
    logic [ADDR_W-1:0] irq_vector_addr;
    logic [4:0] irq_number;
    logic select;
    logic unlock;
    logic [2:0] unlock_cnt;
    logic post_write;
    logic blocked;
  } rivp_state_type;

  rivp_state_type st;
  rivp_state_type next_st;

  // base plus slot; slot of source i sits two words per step above the table start
  function automatic logic [ADDR_W-1:0] vec_addr(input logic sel,
                                                 input logic [ADDR_W-1:0] boot,
                                                 input logic [4:0] idx);
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] slot;
    base = sel ? boot : ADDR_W'(rivp_pkg::RESET_ADDR);
    slot = ADDR_W'(rivp_pkg::TABLE_OFFSET) + (ADDR_W'(idx) << rivp_pkg::SLOT_SHIFT);
    return ADDR_W'(base + slot);
  endfunction

  // lowest set bit wins
  function automatic logic [4:0] lowest(input logic [NUM_SRC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  logic [NUM_SRC-1:0] pending;
  assign pending = global_irq_enable ? irq_request : '0;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.fuse_sync = {st.fuse_sync[1:0], boot_reset_select_fuse};
    next_st.reset_load_valid = 1'b0;
    // reset target waits for the synchroniser to fill and agree
    case (st.phase)
      rivp_pkg::RIVP_SETTLE: begin
        if (st.settle != 2'h0) begin
          next_st.settle = st.settle - 2'h1;
        end else if (st.fuse_sync[1] == st.fuse_sync[2]) begin
          next_st.fuse_prog = (st.fuse_sync[2] == rivp_pkg::FUSE_PROGRAMMED);
          next_st.phase = rivp_pkg::RIVP_BOOT;
        end
      end
      rivp_pkg::RIVP_BOOT: begin
        // fuse alone picks the reset target
        next_st.pc_load_addr = st.fuse_prog ? boot_reset_addr
                                            : ADDR_W'(rivp_pkg::RESET_ADDR);
        next_st.reset_load_valid = 1'b1;
        next_st.phase = rivp_pkg::RIVP_RUN;
      end
      rivp_pkg::RIVP_RUN: begin
        next_st.phase = rivp_pkg::RIVP_RUN;
      end
      default: begin
        next_st.phase = rivp_pkg::RIVP_SETTLE;
      end
    endcase

    // unlock window counts down; expiry clears it
    if (st.unlock) begin
      if (st.unlock_cnt == 3'h1) begin
        next_st.unlock = 1'b0;
      end
      next_st.unlock_cnt = st.unlock_cnt - 3'h1;
    end
    // instruction after the select write ends the hold
    if (st.post_write && instr_done) begin
      next_st.post_write = 1'b0;
    end
    if (ctl_write) begin
      if (ctl_unlock_wr) begin
        next_st.unlock = 1'b1;
        next_st.unlock_cnt = rivp_pkg::UNLOCK_LOAD;
      end else if (st.unlock) begin
        // select moves only inside the window; write also closes it
        next_st.select = ctl_select_wr;
        next_st.unlock = 1'b0;
        next_st.unlock_cnt = 3'h0;
        next_st.post_write = 1'b1;
      end
    end
    // blocking leaves the global enable untouched
    next_st.blocked = next_st.unlock | next_st.post_write;

    // offer one vector at a time; held until taken, withdrawn when blocked
    if (next_st.blocked || st.phase != rivp_pkg::RIVP_RUN) begin
      next_st.irq_valid = 1'b0;
    end else if (st.irq_valid && !irq_take) begin
      next_st.irq_valid = 1'b1;
    end else if (pending != '0 && !(st.irq_valid && irq_take)) begin
      // a slot address is produced only for a pending source
      next_st.irq_valid = 1'b1;
      next_st.irq_number = lowest(pending);
      next_st.irq_vector_addr = vec_addr(st.select, boot_reset_addr,
                                         lowest(pending));
    end else begin
      next_st.irq_valid = 1'b0;
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.phase <= rivp_pkg::RIVP_SETTLE;
      st.settle <= rivp_pkg::SETTLE_LOAD;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign reset_load_valid = st.reset_load_valid;
  assign pc_load_addr = st.pc_load_addr;
  assign irq_valid = st.irq_valid;
  assign irq_vector_addr = st.irq_vector_addr;
  assign irq_number = st.irq_number;
  assign vector_table_select = st.select;
  assign vector_change_unlock = st.unlock;
  assign irq_blocked = st.blocked;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  property p_reset_target;
    @(posedge clk) disable iff (sys_rst)
    reset_load_valid |-> pc_load_addr == (st.fuse_prog ? $past(boot_reset_addr) : '0);
  endproperty
  a_reset_target: assert property (p_reset_target)
    else $error("reset target wrong");

  property p_fuse_code;
    @(posedge clk) disable iff (sys_rst)
    $rose(reset_load_valid) |-> st.fuse_prog == !$past(st.fuse_sync[2], 2);
  endproperty
  a_fuse_code: assert property (p_fuse_code)
    else $error("fuse coding inverted");

  property p_ext0_slot;
    @(posedge clk) disable iff (sys_rst)
    irq_valid && irq_number == 5'h00 && !vector_table_select |-> irq_vector_addr == 14'h0002;
  endproperty
  a_ext0_slot: assert property (p_ext0_slot)
    else $error("external request 0 slot wrong");

  property p_timer_slot;
    @(posedge clk) disable iff (sys_rst)
    irq_valid && irq_number == 5'h0A && !vector_table_select |-> irq_vector_addr == 14'h0016;
  endproperty
  a_timer_slot: assert property (p_timer_slot)
    else $error("timer overflow slot wrong");

  property p_serial_slot;
    @(posedge clk) disable iff (sys_rst)
    irq_valid && irq_number == 5'h0B && !vector_table_select |-> irq_vector_addr == 14'h0018;
  endproperty
  a_serial_slot: assert property (p_serial_slot)
    else $error("serial transfer slot wrong");

  property p_store_slot;
    @(posedge clk) disable iff (sys_rst)
    irq_valid && irq_number == 5'h13 && !vector_table_select |-> irq_vector_addr == 14'h0028;
  endproperty
  a_store_slot: assert property (p_store_slot)
    else $error("store ready slot wrong");

  property p_moved_table;
    @(posedge clk) disable iff (sys_rst)
    $rose(irq_valid) && vector_table_select && $stable(boot_reset_addr) |->
      irq_vector_addr == 14'(boot_reset_addr + 14'h0002 + (14'(irq_number) << 1));
  endproperty
  a_moved_table: assert property (p_moved_table)
    else $error("moved table address wrong");

  property p_taken_only_pending;
    @(posedge clk) disable iff (sys_rst)
    $rose(irq_valid) |-> (($past(irq_request) >> irq_number) & 1) != 0 && $past(global_irq_enable);
  endproperty
  a_taken_only_pending: assert property (p_taken_only_pending)
    else $error("vector offered without request");

  property p_unlock_expires;
    @(posedge clk) disable iff (sys_rst)
    $rose(vector_change_unlock) |-> ##[1:4] !vector_change_unlock;
  endproperty
  a_unlock_expires: assert property (p_unlock_expires)
    else $error("unlock outlived its window");

  property p_select_guarded;
    @(posedge clk) disable iff (sys_rst)
    $changed(vector_table_select) |-> $past(vector_change_unlock) && !vector_change_unlock;
  endproperty
  a_select_guarded: assert property (p_select_guarded)
    else $error("select changed without unlock");

  property p_block_offer;
    @(posedge clk) disable iff (sys_rst)
    vector_change_unlock || irq_blocked |-> !irq_valid;
  endproperty
  a_block_offer: assert property (p_block_offer)
    else $error("vector offered while blocked");

  property p_lowest_first;
    @(posedge clk) disable iff (sys_rst)
    $rose(irq_valid) |->
      ($past(irq_request) & ((32'h0000_0001 << irq_number) - 32'h0000_0001)) == '0;
  endproperty
  a_lowest_first: assert property (p_lowest_first)
    else $error("lower vector skipped");

endmodule

/* File: test/rivp_core_model.sv */
// Purpose: behavioural core side that accepts offered vectors
// Assumes: an offer is a level that stands until it is taken
// Notes: take_delay 0 answers at once, larger values stall the core
`timescale 1ns/100ps
module rivp_core_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic irq_valid,
  input wire logic [3:0] take_delay,
  output logic irq_take
);
  int cnt;

  // ---------------------------------------------
  // accept path
  // ---------------------------------------------
  // take is one cycle long and only follows a standing offer
  initial irq_take = 1'b0;
  always @(posedge clk) begin
    if (sys_rst || irq_take || !irq_valid) begin
      cnt = 0;
      irq_take <= #1 1'b0;
    end else if (cnt >= int'(take_delay)) begin
      irq_take <= #1 1'b1;
    end else begin
      cnt = cnt + 1;
    end
  end
endmodule

/* File: test/reset_irq_vector_placement_tb.sv */
// Purpose: self-checking bench for reset target and vector placement
// Assumes: inputs change 1 ns after the rising edge
// Notes: the core model accepts offers, the bench acts as peripherals
`timescale 1ns/100ps
module reset_irq_vector_placement_tb;
  logic clk, sys_rst, fuse, ena, done, wr, unl, sel, rv, iv, vs, vu, blk, take;
  logic [13:0] boot, pca, va;
  logic [19:0] req;
  logic [4:0] num;
  logic [3:0] dly;
  int bad_count = 0;
  int total_checks = 0;

  // ---------------------------------------------
  // clock, design and core model
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  rivp_vector_place dut (.clk(clk), .sys_rst(sys_rst), .boot_reset_select_fuse(fuse),
    .boot_reset_addr(boot), .irq_request(req), .global_irq_enable(ena), .irq_take(take),
    .instr_done(done), .ctl_write(wr), .ctl_unlock_wr(unl), .ctl_select_wr(sel),
    .reset_load_valid(rv), .pc_load_addr(pca), .irq_valid(iv), .irq_vector_addr(va),
    .irq_number(num), .vector_table_select(vs), .vector_change_unlock(vu),
    .irq_blocked(blk));
  rivp_core_model core (.clk(clk), .sys_rst(sys_rst), .irq_valid(iv),
    .take_delay(dly), .irq_take(take));

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task step;
    @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // reset with a fuse level, then wait for the one-shot load
  task do_reset(input logic f);
    fuse = f;
    sys_rst = 1'b1;
    repeat (2) step;
    sys_rst = 1'b0;
    repeat (20) if (rv !== 1'b1) step;
    chk("rst_pulse", 14'h0001, 14'(rv));
    chk("pc_load", f ? rivp_pkg::RESET_ADDR : boot, pca);
  endtask
  // raise requests, compare the offer, drop them once the core took it
  task offer(input logic [19:0] r, input int n, input logic [13:0] base);
    req = r;
    repeat (40) if (iv !== 1'b1) step;
    chk("offer_valid", 14'h0001, 14'(iv));
    chk("vec_addr", 14'(base + rivp_pkg::TABLE_OFFSET + 14'(2 * n)), va);
    chk("irq_num", 14'(n), 14'(num));
    // take is read on the edge: it has stood since the cycle before, no race with the model
    repeat (20) if (take !== 1'b1) @(posedge clk);
    chk("core_take", 14'h0001, 14'(take));
    // peripheral clears its request as the vector is taken, so no second offer follows
    #1;
    req = '0;
    step;
  endtask
  task ctl(input logic u, input logic s);
    wr = 1'b1;
    unl = u;
    sel = s;
    step;
    wr = 1'b0;
  endtask

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    #40000;
    bad_count++;
    end_of_test;
  end
  // main sequence
  initial begin
    {sys_rst, fuse, ena, done, wr, unl, sel} = 7'h60;
    boot = 14'h3800;
    req = '0;
    dly = 4'h0;
    do_reset(1'b1);
    ena = 1'b1;
    for (int i = 0; i < 20; i++) begin
      dly = 4'((i % 2) * 3);
      offer(20'h0_0001 << i, i, 14'h0000);
    end
    offer(20'h0_1080, 7, 14'h0000);
    $display("test vectors done");
    ena = 1'b0;
    req = 20'h0_0010;
    repeat (10) step;
    chk("no_offer", 14'h0000, 14'(iv));
    req = '0;
    ena = 1'b1;
    $display("test masked done");
    // unlock left to expire, late select write ignored
    ctl(1'b1, 1'b1);
    step;
    chk("unlock_open", 14'h0001, 14'(vu));
    chk("blocked_open", 14'h0001, 14'(blk));
    repeat (6) step;
    chk("unlock_expired", 14'h0000, 14'(vu));
    chk("blocked_expired", 14'h0000, 14'(blk));
    ctl(1'b0, 1'b1);
    step;
    chk("late_select", 14'h0000, 14'(vs));
    $display("test expiry done");
    // proper move with a request pending through the sequence
    ctl(1'b1, 1'b0);
    req = 20'h0_0020;
    // a clock passes so the write strobe is never lowered and raised in one step
    step;
    ctl(1'b0, 1'b1);
    step;
    chk("select_set", 14'h0001, 14'(vs));
    chk("unlock_clr", 14'h0000, 14'(vu));
    chk("held_off", 14'h0000, 14'(iv));
    chk("hold_on", 14'h0001, 14'(blk));
    done = 1'b1;
    step;
    done = 1'b0;
    step;
    step;
    chk("hold_end", 14'h0000, 14'(blk));
    offer(20'h0_0020, 5, boot);
    offer(20'h8_0000, 19, boot);
    $display("test relocate done");
    do_reset(1'b0);
    chk("select_rst", 14'h0000, 14'(vs));
    offer(20'h0_0001, 0, 14'h0000);
    $display("test boot reset done");
    end_of_test;
  end
endmodule
